// ---- hw/scs_top.sv ----
// system clock source select: direct, prescaler, pll and wakeup modes
// How it works
// - select 11 drives clock from external pin
// - select 10 with bypass divides by prescaler
// - prescaler input is crystal or internal oscillator
// - prescaler factor is field plus one, max 1024
// - factor one passes input clock unchanged
// - crystal bypass divide one equals direct drive
// - select 10 without bypass runs the pll
// - pll multiplies by N over P times K2
// - pll reference is crystal or internal oscillator
// - system clock is vco divided by K2
// - two-bit band picks the vco range
// - select 00 runs from wakeup clock
`timescale 1ns/100ps
`default_nettype none
module scs_top
  import scs_pkg::*;
#(
  parameter int K1_W = SCS_K1_W,
  parameter int K2_W = SCS_K2_W,
  parameter int P_W = SCS_P_W,
  parameter int N_W = SCS_N_W
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ext_clock_in_pin_i,
  input wire logic crystal_in_pin_i,
  input wire logic int_osc_clk_i,
  input wire logic wakeup_clk_i,
  input wire logic pll_vco_clk_i,
  input wire logic [1:0] clock_source_select_i,
  input wire logic vco_bypass_i,
  input wire logic osc_input_select_i,
  input wire logic [K1_W-1:0] prescaler_div_field_i,
  input wire logic [P_W-1:0] pll_input_div_field_i,
  input wire logic [N_W-1:0] pll_feedback_mult_field_i,
  input wire logic [K2_W-1:0] pll_output_div_field_i,
  input wire logic [1:0] vco_band_select_i,
  output logic sys_clk_o,
  output logic pll_enable_o,
  output logic pll_ref_clk_o,
  output logic [P_W-1:0] pll_input_div_o,
  output logic [N_W-1:0] pll_feedback_mult_o,
  output logic [1:0] vco_band_o,
  output logic [1:0] active_mode_o
);
  // ****************************************
  // pin synchronisers
  // ****************************************
  localparam int NSRC = 5;
  localparam int I_EXT = 0;
  localparam int I_XTAL = 1;
  localparam int I_INT = 2;
  localparam int I_WAKE = 3;
  localparam int I_VCO = 4;

  logic [NSRC-1:0] pins;
  logic [NSRC-1:0] meta_q;
  logic [NSRC-1:0] sync_q;
  logic [NSRC-1:0] prev_q;
  logic [NSRC-1:0] rise;

  assign pins = {pll_vco_clk_i, wakeup_clk_i, int_osc_clk_i, crystal_in_pin_i, ext_clock_in_pin_i};

  // two flops per pin, then one more for edge detection
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise = sync_q & ~prev_q;

  // ****************************************
  // oscillator choice for prescaler and pll reference
  // ****************************************
  logic osc_level;
  logic osc_rise;

  // crystal when low, internal source when high
  assign osc_level = osc_input_select_i ? sync_q[I_INT] : sync_q[I_XTAL];
  assign osc_rise = osc_input_select_i ? rise[I_INT] : rise[I_XTAL];

  // ****************************************
  // dividers
  // ****************************************
  scs_div_if #(.W(K1_W)) k1_if ();
  scs_div_if #(.W(K2_W)) k2_if ();

  // prescaler divides the oscillator by field plus one
  assign k1_if.field = prescaler_div_field_i;
  assign k1_if.in_level = osc_level;
  assign k1_if.in_rise = osc_rise;

  // vco output divided by K2 gives the pll system clock
  assign k2_if.field = pll_output_div_field_i;
  assign k2_if.in_level = sync_q[I_VCO];
  assign k2_if.in_rise = rise[I_VCO];

  scs_divider #(.W(K1_W)) u_k1 (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .port_if(k1_if)
  );

  scs_divider #(.W(K2_W)) u_k2 (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .port_if(k2_if)
  );

  // ****************************************
  // source selection
  // ****************************************
  scs_state_t want;
  scs_state_t state_q;
  logic want_level;
  logic cur_level;

  // requested source from select field and bypass bit
  always_comb begin
    case (clock_source_select_i)
      SCS_SEL_DIRECT: want = SCS_ST_DIRECT;
      SCS_SEL_OSC: want = vco_bypass_i ? SCS_ST_PRESC : SCS_ST_PLL;
      SCS_SEL_WAKEUP: want = SCS_ST_WAKE;
      default: want = SCS_ST_WAKE;
    endcase
  end

  // level of a source in a given state
  function automatic logic src_level(input scs_state_t s, input logic [NSRC-1:0] lv, input logic k1,
                                     input logic k2);
    case (s)
      SCS_ST_DIRECT: src_level = lv[I_EXT];
      SCS_ST_PRESC: src_level = k1;
      SCS_ST_PLL: src_level = k2;
      SCS_ST_WAKE: src_level = lv[I_WAKE];
      default: src_level = 1'b0;
    endcase
  endfunction

  assign want_level = src_level(want, sync_q, k1_if.out_level, k2_if.out_level);
  assign cur_level = src_level(state_q, sync_q, k1_if.out_level, k2_if.out_level);

  // switch only while the output and the new source are both low
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= SCS_ST_WAKE;
    end else if (want != state_q && !sys_clk_o && !want_level) begin
      state_q <= want;
    end
  end

  // output holds low during a pending switch so no pulse is cut short
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sys_clk_o <= SCS_CLK_RST;
    end else if (want != state_q && !sys_clk_o) begin
      sys_clk_o <= 1'b0;
    end else begin
      sys_clk_o <= cur_level;
    end
  end

  // ****************************************
  // pll macro control and status
  // ****************************************
  // pll runs while pll mode is requested or active, fields pass to the analog loop
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      pll_enable_o <= 1'b0;
      pll_ref_clk_o <= 1'b0;
      pll_input_div_o <= '0;
      pll_feedback_mult_o <= '0;
      vco_band_o <= SCS_BAND_LOW;
    end else begin
      pll_enable_o <= (want == SCS_ST_PLL) || (state_q == SCS_ST_PLL);
      pll_ref_clk_o <= osc_level;
      pll_input_div_o <= pll_input_div_field_i;
      pll_feedback_mult_o <= pll_feedback_mult_field_i;
      vco_band_o <= vco_band_select_i;
    end
  end

  // active source reported as select code, bypass folded in
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      active_mode_o <= SCS_ACTIVE_RST;
    end else begin
      case (state_q)
        SCS_ST_DIRECT: active_mode_o <= SCS_SEL_DIRECT;
        SCS_ST_PRESC: active_mode_o <= SCS_SEL_OSC;
        SCS_ST_PLL: active_mode_o <= SCS_SEL_SPARE;
        SCS_ST_WAKE: active_mode_o <= SCS_SEL_WAKEUP;
        default: active_mode_o <= SCS_SEL_WAKEUP;
      endcase
    end
  end
endmodule
`default_nettype wire

// ---- hw/scs_pkg.sv ----
// constants shared by the system clock source select block
package scs_pkg;
  // ****************************************
  // clock source select codes
  // ****************************************
  localparam logic [1:0] SCS_SEL_WAKEUP = 2'h0;
  localparam logic [1:0] SCS_SEL_SPARE = 2'h1;
  localparam logic [1:0] SCS_SEL_OSC = 2'h2;
  localparam logic [1:0] SCS_SEL_DIRECT = 2'h3;

  // ****************************************
  // vco band codes
  // ****************************************
  localparam logic [1:0] SCS_BAND_LOW = 2'h0;  // 50 to 110 MHz
  localparam logic [1:0] SCS_BAND_MID = 2'h1;  // 100 to 200 MHz
  localparam logic [1:0] SCS_BAND_HIGH = 2'h2; // 200 to 280 MHz

  // ****************************************
  // field widths and reset values
  // ****************************************
  localparam int SCS_K1_W = 10;
  localparam int SCS_K2_W = 7;
  localparam int SCS_P_W = 4;
  localparam int SCS_N_W = 8;
  localparam int SCS_SYNC_STAGES = 2;
  localparam logic SCS_CLK_RST = 1'b0;
  localparam logic [1:0] SCS_ACTIVE_RST = SCS_SEL_WAKEUP;

  // ****************************************
  // active source states, one-hot
  // ****************************************
  typedef enum logic [3:0] {
    SCS_ST_WAKE = 4'h1,
    SCS_ST_DIRECT = 4'h2,
    SCS_ST_PRESC = 4'h4,
    SCS_ST_PLL = 4'h8
  } scs_state_t;
endpackage

// ---- hw/scs_div_if.sv ----
// signals between the top and one clock divider
`timescale 1ns/100ps
`default_nettype none
interface scs_div_if #(
  parameter int W = 10
);
  logic [W-1:0] field;     // programmed factor minus one
  logic in_level;          // synchronised input clock level
  logic in_rise;           // one-cycle pulse on input rising edge
  logic out_level;         // divided clock level

  modport ctrl (output field, output in_level, output in_rise, input out_level);
  modport div (input field, input in_level, input in_rise, output out_level);
endinterface
`default_nettype wire

// ---- hw/scs_divider.sv ----
// integer clock divider on input periods, glitch free across factor changes
`timescale 1ns/100ps
`default_nettype none
module scs_divider
  import scs_pkg::*;
#(
  parameter int W = 10
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  scs_div_if.div port_if
);
  logic [W:0] fact_q;
  logic [W:0] cnt_q;
  logic out_q;
  logic last;
  logic [W:0] cnt_nx;
  logic [W:0] fact_nx;

  // factor is field plus one
  function automatic logic [W:0] plus_one(input logic [W-1:0] f);
    plus_one = {1'b0, f} + {{W{1'b0}}, 1'b1};
  endfunction

  // ****************************************
  // period counting
  // ****************************************
  // a new factor is taken only at the end of a whole output period
  assign last = (cnt_q == fact_q - {{W{1'b0}}, 1'b1});
  assign fact_nx = last ? plus_one(port_if.field) : fact_q;
  assign cnt_nx = last ? '0 : cnt_q + {{W{1'b0}}, 1'b1};

  // counter and factor advance on each input rising edge
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fact_q <= {{W{1'b0}}, 1'b1};
      cnt_q <= '0;
    end else if (port_if.in_rise) begin
      fact_q <= fact_nx;
      cnt_q <= cnt_nx;
    end
  end

  // output high for the first half of the period, changes only on input rise
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      out_q <= SCS_CLK_RST;
    end else if (port_if.in_rise) begin
      out_q <= ({1'b0, cnt_nx} < ({1'b0, fact_nx} + 1'b1) >> 1);
    end
  end

  // factor one passes the input through with its own duty cycle
  assign port_if.out_level = (fact_q == {{W{1'b0}}, 1'b1}) ? port_if.in_level : out_q;
endmodule
`default_nettype wire

// ---- verification/scs_src_model.sv ----
// free-running clock sources on the far side of the block
`timescale 1ns/100ps
`default_nettype none
module scs_src_model (
  output logic ext_o,
  output logic xtal_o,
  output logic osc_o,
  output logic wake_o,
  output logic vco_o
);
  // one source: high then low time in ns, kept off the core edges
  task automatic gen(ref logic c, input int hi, input int lo);
    c = 1'b0;
    #3;
    forever begin
      c = 1'b1;
      #(hi);
      c = 1'b0;
      #(lo);
    end
  endtask
  // uneven duty on pin and crystal shows up any reshaping
  initial gen(ext_o, 30, 70);
  initial gen(xtal_o, 60, 100);
  initial gen(osc_o, 110, 110);
  initial gen(wake_o, 350, 350);
  initial gen(vco_o, 40, 40);
endmodule
`default_nettype wire

// ---- verification/scs_top_sva.sv ----
// assertions on the ports of the clock source select block
`timescale 1ns/100ps
`default_nettype none
module scs_top_sva
  import scs_pkg::*;
#(
  parameter int P_W = SCS_P_W,
  parameter int N_W = SCS_N_W
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ext_clock_in_pin_i,
  input wire logic crystal_in_pin_i,
  input wire logic int_osc_clk_i,
  input wire logic wakeup_clk_i,
  input wire logic [1:0] clock_source_select_i,
  input wire logic vco_bypass_i,
  input wire logic osc_input_select_i,
  input wire logic [P_W-1:0] pll_input_div_field_i,
  input wire logic [N_W-1:0] pll_feedback_mult_field_i,
  input wire logic [1:0] vco_band_select_i,
  input wire logic sys_clk_o,
  input wire logic pll_enable_o,
  input wire logic pll_ref_clk_o,
  input wire logic [P_W-1:0] pll_input_div_o,
  input wire logic [N_W-1:0] pll_feedback_mult_o,
  input wire logic [1:0] vco_band_o,
  input wire logic [1:0] active_mode_o
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  logic [13:0] hold_q;
  logic [1:0] want;
  // cycles the mode request has held still
  always_ff @(posedge core_clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_q <= 14'h0000;
    end else if (!$stable({clock_source_select_i, vco_bypass_i})) begin
      hold_q <= 14'h0000;
    end else if (hold_q != 14'h3FFF) begin
      hold_q <= hold_q + 14'h0001;
    end
  end
  // mode the request asks for
  assign want = (clock_source_select_i == SCS_SEL_DIRECT) ? 2'h3 :
                (clock_source_select_i != SCS_SEL_OSC) ? 2'h0 : (vco_bypass_i ? 2'h2 : 2'h1);
  sequence s_swap;
    $changed(active_mode_o);
  endsequence
  sequence s_up;
    $rose(sys_clk_o);
  endsequence
  a_mode_settles: assert property (hold_q > 14'h2328 |-> active_mode_o == want)
    else $error("active mode differs from settled request");
  a_swap_low: assert property (s_swap |-> !$past(sys_clk_o))
    else $error("source switched while clock high");
  a_direct_rise: assert property (active_mode_o == 2'h3 ##0 s_up |-> $past(ext_clock_in_pin_i, 2) && $past(ext_clock_in_pin_i, 3))
    else $error("direct clock rose without pin high");
  a_wake_rise: assert property (active_mode_o == 2'h0 ##0 s_up |-> $past(wakeup_clk_i, 2) && $past(wakeup_clk_i, 3))
    else $error("wakeup clock rose without source high");
  a_ref_src: assert property ($rose(pll_ref_clk_o) |-> ($past(osc_input_select_i) ? $past(int_osc_clk_i, 3) : $past(crystal_in_pin_i, 3)))
    else $error("reference rose without selected source high");
  a_fwd_pll_input_div_field: assert property (!$past(rst_i) |-> pll_input_div_o == $past(pll_input_div_field_i))
    else $error("input divider copy wrong");
  a_fwd_nmul: assert property (!$past(rst_i) |-> pll_feedback_mult_o == $past(pll_feedback_mult_field_i))
    else $error("feedback factor copy wrong");
  a_fwd_band: assert property (!$past(rst_i) |-> vco_band_o == $past(vco_band_select_i))
    else $error("band copy wrong");
  a_pll_req: assert property (!$past(rst_i) && $past(want) == 2'h1 |-> pll_enable_o)
    else $error("loop not enabled when requested");
endmodule
bind scs_top scs_top_sva #(.P_W(P_W), .N_W(N_W)) scs_top_sva_inst (.core_clk_i, .rst_i, .ext_clock_in_pin_i,
  .crystal_in_pin_i, .int_osc_clk_i, .wakeup_clk_i, .clock_source_select_i, .vco_bypass_i, .osc_input_select_i,
  .pll_input_div_field_i, .pll_feedback_mult_field_i, .vco_band_select_i, .sys_clk_o, .pll_enable_o,
  .pll_ref_clk_o, .pll_input_div_o, .pll_feedback_mult_o, .vco_band_o, .active_mode_o);
`default_nettype wire

// ---- verification/scs_top_tb.sv ----
// self-checking bench for the clock source select block
`timescale 1ns/100ps
`default_nettype none
module scs_top_tb;
  logic core_clk_i = 1'b0, rst_i = 1'b1, vco_bypass_i, osc_input_select_i;
  logic ext_clock_in_pin_i, crystal_in_pin_i, int_osc_clk_i, wakeup_clk_i, pll_vco_clk_i, prev_q = 1'b0;
  logic [1:0] clock_source_select_i, vco_band_select_i, vco_band_o, active_mode_o;
  logic [9:0] prescaler_div_field_i;
  logic [3:0] pll_input_div_field_i, pll_input_div_o;
  logic [7:0] pll_feedback_mult_field_i, pll_feedback_mult_o;
  logic [6:0] pll_output_div_field_i;
  logic sys_clk_o, pll_enable_o, pll_ref_clk_o;
  int error_cnt = 0, n_tests = 0, cyc = 0, t_rise = 0, t_fall = 0, per = 0, hi = 0, rises = 0;
  // rows of select, bypass, oscillator choice, factor field
  // every row stays far below 80 MHz, so no safe flash step is owed
  int plan[$] = '{3, 0, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0, 2, 1, 0, 0, 2, 1, 0, 2, 2, 1, 1, 1, 2, 0, 0, 3, 2, 0, 1, 0};
  always #5 core_clk_i = ~core_clk_i;
  scs_src_model scs_src_model_inst (.ext_o(ext_clock_in_pin_i), .xtal_o(crystal_in_pin_i),
    .osc_o(int_osc_clk_i), .wake_o(wakeup_clk_i), .vco_o(pll_vco_clk_i));
  scs_top scs_top_inst (.core_clk_i, .rst_i, .ext_clock_in_pin_i, .crystal_in_pin_i, .int_osc_clk_i, .wakeup_clk_i,
    .pll_vco_clk_i, .clock_source_select_i, .vco_bypass_i, .osc_input_select_i, .prescaler_div_field_i,
    .pll_input_div_field_i, .pll_feedback_mult_field_i, .pll_output_div_field_i, .vco_band_select_i, .sys_clk_o,
    .pll_enable_o, .pll_ref_clk_o, .pll_input_div_o, .pll_feedback_mult_o, .vco_band_o, .active_mode_o);
  // times the generated clock edges in core cycles
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    prev_q <= sys_clk_o;
    if (sys_clk_o && !prev_q) begin
      per <= cyc - t_rise;
      hi <= t_fall - t_rise;
      t_rise <= cyc;
      rises <= rises + 1;
    end
    if (!sys_clk_o && prev_q) t_fall <= cyc;
  end
  // expected period or high time from source timing and factor
  function automatic int exp_val(int s, int b, int o, int k, bit want_hi);
    int p, h, m;
    p = s == 3 ? 10 : s != 2 ? 70 : !b ? 8 : o ? 22 : 16;
    h = s == 3 ? 3 : s != 2 ? 35 : !b ? 4 : o ? 11 : 6;
    m = s == 2 ? k + 1 : 1;
    return want_hi ? (m == 1 ? h : (m + 1) / 2 * p) : m * p;
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %0h exp %0h", $time, seen, exp);
    end
  endtask
  task automatic results();
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    // quiet settings while reset is held
    clock_source_select_i <= 2'h0;
    vco_bypass_i <= 1'b0;
    osc_input_select_i <= 1'b0;
    vco_band_select_i <= 2'h0;
    prescaler_div_field_i <= 10'h000;
    pll_input_div_field_i <= 4'h0;
    pll_feedback_mult_field_i <= 8'h00;
    pll_output_div_field_i <= 7'h00;
    void'($urandom(32'h64DF));
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    plan.push_back(2); plan.push_back(1); plan.push_back(0); plan.push_back($urandom % 7);
    plan.push_back(2); plan.push_back(0); plan.push_back(1); plan.push_back($urandom % 16);
    plan.push_back(2); plan.push_back(1); plan.push_back(0); plan.push_back(1023);
    for (int i = 0; i < plan.size(); i += 4) begin
      @(posedge core_clk_i);
      clock_source_select_i <= 2'(plan[i]); // whole setting in one edge
      vco_bypass_i <= plan[i + 1][0];
      osc_input_select_i <= plan[i + 2][0];
      prescaler_div_field_i <= 10'(plan[i + 3]);
      pll_output_div_field_i <= 7'(plan[i + 3]);
      pll_input_div_field_i <= 4'($urandom);
      pll_feedback_mult_field_i <= 8'($urandom);
      vco_band_select_i <= 2'(i / 4 % 3);
      for (int r = rises + 3; rises < r;) @(posedge core_clk_i);
      check(16'(per), 16'(exp_val(plan[i], plan[i + 1], plan[i + 2], plan[i + 3], 0)));
      check(16'(hi), 16'(exp_val(plan[i], plan[i + 1], plan[i + 2], plan[i + 3], 1)));
      check(16'({vco_band_o, pll_feedback_mult_o, pll_input_div_o}),
        16'({vco_band_select_i, pll_feedback_mult_field_i, pll_input_div_field_i}));
      check(16'(pll_enable_o), 16'(plan[i] == 2 && plan[i + 1] == 0));
      check(16'(active_mode_o), 16'(plan[i] == 3 ? 3 : plan[i] != 2 ? 0 : plan[i + 1] ? 2 : 1));
    end
    results();
  end
  // cuts a hung run short: the plan needs about 35000 cycles, the last row most of them
  initial begin
    #900000;
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
